/* File: logic/msgbuf_fields.sv */
// one message buffer: data bytes, length, configuration, identifier, store policy
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module msgbuf_fields (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// register port
	input wire logic [msgbuf_pkg::ADDR_W-1:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	// transmit view for the protocol engine
	output msgbuf_pkg::frame_t TX_FRAME,
	output logic [msgbuf_pkg::NUM_W-1:0] TX_NBYTES,
	output logic TX_ENABLED,
	// receive offer from the protocol engine
	input wire logic RX_VALID,
	input msgbuf_pkg::frame_t RX_FRAME,
	output logic RX_STORED,
	output logic RX_DROPPED,
	// buffer role and status
	output logic [2:0] BUF_TYPE,
	output logic BUF_ASSIGNED,
	output logic ID_EXT,
	output logic DATA_STORED
);
	import msgbuf_pkg::*;

	state_t s_q, s_d;
	logic is_tx, is_rx, id_match, accept, nb_over;
	logic [3:0] nb;

	// byte count for a length code, capped at eight
	function automatic logic [3:0] cap_len(input logic [3:0] c);
		cap_len = (c > LEN_MAX) ? LEN_MAX : c;
	endfunction : cap_len

	// compare id; standard format looks at the top eleven bits only
	function automatic logic id_eq(input logic ext, input logic [28:0] a, input logic [28:0] b);
		if (ext) begin
			id_eq = (a == b);
		end else begin
			id_eq = (a[28:18] == b[28:18]);
		end
	endfunction : id_eq

	always_comb begin
		s_d = s_q;
		s_d.store_ack = 1'b0;
		s_d.drop_ack = 1'b0;
		s_d.rdata = 16'h0000;
		nb = cap_len(RX_FRAME.dlc);
		is_tx = s_q.conf[CONF_MT_LO+:3] == MT_TX;
		is_rx = !is_tx && s_q.conf[CONF_MT_LO+:3] <= MT_RX_LAST;
		id_match = RX_FRAME.ext == s_q.idh[IDH_IDE]
			&& id_eq(s_q.idh[IDH_IDE], {s_q.idh[12:0], s_q.idl}, RX_FRAME.id);
		accept = 1'b0;
		// mask filtering lives outside; the engine offers only frames passing the mask
		if (RX_VALID && s_q.conf[CONF_ASSIGN] && id_match) begin
			if (RX_FRAME.remote) begin
				// remote frames bypass overwrite policy
				accept = is_tx && !s_q.conf[CONF_RTR] && !s_q.transmit_request_bit;
			end else begin
				accept = is_rx && (!s_q.dn || s_q.conf[CONF_OWS]);
			end
		end
		if (RX_VALID && !accept) begin
			s_d.drop_ack = 1'b1;
		end
		// software access
		if (WR) begin
			if (ADDR <= A_BYTE7) begin
				s_d.data[ADDR[2:0]*8+:8] = WDATA[7:0];
			end else if (ADDR <= A_PAIR67) begin
				s_d.data[ADDR[1:0]*16+:16] = WDATA;
			end else begin
				unique case (ADDR)
					A_LEN: s_d.len = WDATA[3:0];
					A_CONF: s_d.conf = WDATA[7:0] & CONF_WMASK;
					A_IDL: s_d.idl = WDATA;
					A_IDH: s_d.idh = WDATA & IDH_WMASK;
					A_CTRL: begin
						if (WDATA[CTRL_DN]) s_d.dn = 1'b0;
						s_d.transmit_request_bit = WDATA[CTRL_TRQ];
						if (WDATA[CTRL_OVW]) s_d.ovw = 1'b0;
					end
					default: ;
				endcase
			end
		end
		if (RD) begin
			if (ADDR <= A_BYTE7) begin
				s_d.rdata = {8'h00, s_q.data[ADDR[2:0]*8+:8]};
			end else if (ADDR <= A_PAIR67) begin
				s_d.rdata = s_q.data[ADDR[1:0]*16+:16];
			end else begin
				unique case (ADDR)
					A_LEN: s_d.rdata = {8'h00, ZERO4, s_q.len};
					A_CONF: s_d.rdata = {8'h00, s_q.conf};
					A_IDL: s_d.rdata = s_q.idl;
					A_IDH: s_d.rdata = s_q.idh;
					A_CTRL: s_d.rdata = {13'h0000, s_q.ovw, s_q.transmit_request_bit, s_q.dn};
					default: s_d.rdata = 16'h0000;
				endcase
			end
		end
		// storage wins over a same-cycle software write
		if (accept) begin
			s_d.store_ack = 1'b1;
			s_d.len = RX_FRAME.dlc;
			if (!RX_FRAME.remote) begin
				nb = cap_len(RX_FRAME.dlc);
				for (int i = 0; i < DATA_BYTES; i++) begin
					if (i < int'(nb)) s_d.data[i*8+:8] = RX_FRAME.data[i*8+:8];
				end
				if (s_q.dn) s_d.ovw = 1'b1;
				s_d.idl = RX_FRAME.id[15:0];
				s_d.idh[12:0] = RX_FRAME.id[28:16];
			end
			s_d.conf[CONF_RTR] = 1'b0;
			s_d.dn = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// registered transmit view
	logic [3:0] txn_d;
	always_comb begin
		nb_over = s_q.len > LEN_MAX;
		txn_d = s_q.conf[CONF_RTR] ? ZERO4 : (nb_over ? LEN_MAX : s_q.len);
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			TX_FRAME <= '0;
			TX_NBYTES <= '0;
			TX_ENABLED <= 1'b0;
		end else begin
			TX_FRAME.ext <= s_q.idh[IDH_IDE];
			TX_FRAME.id <= s_q.idh[IDH_IDE] ? {s_q.idh[12:0], s_q.idl}
				: {s_q.idh[12:2], STD_LOW_ZERO};
			TX_FRAME.remote <= s_q.conf[CONF_RTR];
			TX_FRAME.dlc <= s_q.len;
			TX_FRAME.data <= s_q.data;
			TX_NBYTES <= txn_d;
			TX_ENABLED <= s_q.transmit_request_bit && s_q.conf[CONF_ASSIGN] && is_tx;
		end
	end

	assign RDATA = s_q.rdata;
	assign RX_STORED = s_q.store_ack;
	assign RX_DROPPED = s_q.drop_ack;
	assign BUF_TYPE = s_q.conf[CONF_MT_LO+:3];
	assign BUF_ASSIGNED = s_q.conf[CONF_ASSIGN];
	assign ID_EXT = s_q.idh[IDH_IDE];
	assign DATA_STORED = s_q.dn;

	// shorthand for the checks below, taken from the storage conditions
	logic data_take, remote_take;
	always_comb begin
		data_take = RX_VALID && !RX_FRAME.remote && is_rx && s_q.conf[CONF_ASSIGN] && id_match
			&& (!s_q.dn || s_q.conf[CONF_OWS]);
		remote_take = RX_VALID && RX_FRAME.remote && is_tx && s_q.conf[CONF_ASSIGN] && id_match
			&& !s_q.conf[CONF_RTR] && !s_q.transmit_request_bit;
	end

	// receive policy for data frames
	a_filled_drop: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && !RX_FRAME.remote && s_q.dn && !s_q.conf[CONF_OWS]
		|=> !RX_STORED)
		else $error("data frame stored into filled buffer");
	a_filled_keep: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && !RX_FRAME.remote && s_q.dn && !s_q.conf[CONF_OWS] && !WR
		|=> s_q.data == $past(s_q.data))
		else $error("filled buffer data changed");
	a_over_take: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && !RX_FRAME.remote && is_rx && s_q.conf[CONF_ASSIGN] && id_match
		&& s_q.conf[CONF_OWS] |=> RX_STORED && DATA_STORED)
		else $error("overwrite frame not stored");
	a_ovw_set: assert property (@(posedge REF_CLK) disable iff (!NRST)
		data_take && s_q.dn
		|=> s_q.ovw)
		else $error("overwrite status not set");
	a_ovw_first: assert property (@(posedge REF_CLK) disable iff (!NRST)
		data_take && !s_q.dn && !s_q.ovw
		|=> !s_q.ovw)
		else $error("overwrite status set on first store");
	a_data_take: assert property (@(posedge REF_CLK) disable iff (!NRST)
		data_take
		|=> RX_STORED && !RX_DROPPED)
		else $error("matching data frame not stored");
	a_rx_len: assert property (@(posedge REF_CLK) disable iff (!NRST)
		data_take
		|=> s_q.len == $past(RX_FRAME.dlc))
		else $error("received length not stored");
	a_rx_byte0: assert property (@(posedge REF_CLK) disable iff (!NRST)
		data_take && RX_FRAME.dlc != ZERO4
		|=> s_q.data[7:0] == $past(RX_FRAME.data[7:0]))
		else $error("first data byte not stored");
	a_rx_byte7: assert property (@(posedge REF_CLK) disable iff (!NRST)
		data_take && RX_FRAME.dlc >= LEN_MAX
		|=> s_q.data[63:56] == $past(RX_FRAME.data[63:56]))
		else $error("last data byte not stored");
	a_rx_keep7: assert property (@(posedge REF_CLK) disable iff (!NRST)
		data_take && RX_FRAME.dlc < LEN_MAX && !WR
		|=> s_q.data[63:56] == $past(s_q.data[63:56]))
		else $error("byte beyond length written");
	a_rx_id_low: assert property (@(posedge REF_CLK) disable iff (!NRST)
		data_take && RX_FRAME.ext
		|=> s_q.idl == $past(RX_FRAME.id[15:0]))
		else $error("received low id not stored");
	a_id_miss: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && !id_match
		|=> RX_DROPPED && !RX_STORED)
		else $error("mismatching id stored");

	// remote frames and frame type against buffer type
	a_remote_block: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && RX_FRAME.remote && s_q.conf[CONF_RTR]
		|=> !RX_STORED)
		else $error("remote frame stored with rtr set");
	a_remote_quiet: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && RX_FRAME.remote && s_q.conf[CONF_RTR] && !WR
		|=> s_q.len == $past(s_q.len) && s_q.dn == $past(s_q.dn))
		else $error("blocked remote frame changed buffer");
	a_remote_trq: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && RX_FRAME.remote && s_q.transmit_request_bit
		|=> !RX_STORED)
		else $error("remote frame stored with trq set");
	a_remote_take: assert property (@(posedge REF_CLK) disable iff (!NRST)
		remote_take
		|=> RX_STORED && DATA_STORED)
		else $error("matching remote frame not stored");
	a_remote_len: assert property (@(posedge REF_CLK) disable iff (!NRST)
		remote_take
		|=> s_q.len == $past(RX_FRAME.dlc))
		else $error("remote length not stored");
	a_remote_no_ovw: assert property (@(posedge REF_CLK) disable iff (!NRST)
		remote_take && !s_q.ovw
		|=> !s_q.ovw)
		else $error("remote store set overwrite status");
	a_remote_data: assert property (@(posedge REF_CLK) disable iff (!NRST)
		remote_take && !WR
		|=> s_q.data == $past(s_q.data))
		else $error("remote store changed data");
	a_rtr_clear: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_STORED
		|-> !s_q.conf[CONF_RTR])
		else $error("rtr set after remote store");
	a_remote_rx_type: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && RX_FRAME.remote && !is_tx
		|=> !RX_STORED)
		else $error("remote frame stored in receive buffer");
	a_data_tx_type: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && !RX_FRAME.remote && is_tx
		|=> !RX_STORED)
		else $error("data frame stored in transmit buffer");

	// stored flag and offer answers
	a_stored_flag: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_STORED
		|-> DATA_STORED)
		else $error("stored flag missing");
	a_flag_rise: assert property (@(posedge REF_CLK) disable iff (!NRST)
		$rose(s_q.dn)
		|-> RX_STORED)
		else $error("stored flag rose without a store");
	a_flag_hold: assert property (@(posedge REF_CLK) disable iff (!NRST)
		s_q.dn && !WR
		|=> s_q.dn)
		else $error("stored flag lost");
	a_answer_excl: assert property (@(posedge REF_CLK) disable iff (!NRST)
		1'b1
		|-> !(RX_STORED && RX_DROPPED))
		else $error("frame both stored and dropped");
	a_idle_quiet: assert property (@(posedge REF_CLK) disable iff (!NRST)
		!RX_VALID
		|=> !RX_STORED && !RX_DROPPED)
		else $error("answer without an offer");
	a_drop_unused: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RX_VALID && !s_q.conf[CONF_ASSIGN]
		|=> RX_DROPPED && !RX_STORED)
		else $error("unused buffer took a frame");

	// configuration and identifier storage
	a_conf_zero: assert property (@(posedge REF_CLK) disable iff (!NRST)
		1'b1
		|-> (s_q.conf & ~CONF_WMASK) == 8'h00)
		else $error("reserved configuration bits set");
	a_idh_zero: assert property (@(posedge REF_CLK) disable iff (!NRST)
		1'b1
		|-> (s_q.idh & ~IDH_WMASK) == 16'h0000)
		else $error("reserved id high bits set");

	// transmit view
	a_tx_count: assert property (@(posedge REF_CLK) disable iff (!NRST)
		s_q.len > LEN_MAX && !s_q.conf[CONF_RTR]
		|=> TX_NBYTES == LEN_MAX)
		else $error("long code not capped at eight");
	a_tx_remote: assert property (@(posedge REF_CLK) disable iff (!NRST)
		s_q.conf[CONF_RTR]
		|=> TX_NBYTES == ZERO4)
		else $error("remote frame carries data");
	a_tx_short: assert property (@(posedge REF_CLK) disable iff (!NRST)
		s_q.len <= LEN_MAX && !s_q.conf[CONF_RTR]
		|=> TX_NBYTES == $past(s_q.len))
		else $error("byte count differs from length");
	a_tx_dlc: assert property (@(posedge REF_CLK) disable iff (!NRST)
		1'b1
		|=> TX_FRAME.dlc == $past(s_q.len))
		else $error("dlc altered");
	a_tx_type: assert property (@(posedge REF_CLK) disable iff (!NRST)
		1'b1
		|=> TX_FRAME.remote == $past(s_q.conf[CONF_RTR]))
		else $error("frame type differs from rtr");
	a_tx_ext: assert property (@(posedge REF_CLK) disable iff (!NRST)
		1'b1
		|=> TX_FRAME.ext == $past(s_q.idh[IDH_IDE]))
		else $error("format bit not sent");
	a_std_low: assert property (@(posedge REF_CLK) disable iff (!NRST)
		!TX_FRAME.ext
		|-> TX_FRAME.id[17:0] == STD_LOW_ZERO)
		else $error("standard id low bits sent");
	a_tx_std_id: assert property (@(posedge REF_CLK) disable iff (!NRST)
		!s_q.idh[IDH_IDE]
		|=> TX_FRAME.id[28:18] == $past(s_q.idh[12:2]))
		else $error("standard id not sent");
	a_tx_ext_id: assert property (@(posedge REF_CLK) disable iff (!NRST)
		s_q.idh[IDH_IDE]
		|=> TX_FRAME.id == {$past(s_q.idh[12:0]), $past(s_q.idl)})
		else $error("extended id not sent");
	a_tx_data: assert property (@(posedge REF_CLK) disable iff (!NRST)
		1'b1
		|=> TX_FRAME.data == $past(s_q.data))
		else $error("transmit data differs from buffer");
	a_tx_enable: assert property (@(posedge REF_CLK) disable iff (!NRST)
		1'b1
		|=> TX_ENABLED == $past(s_q.transmit_request_bit && s_q.conf[CONF_ASSIGN] && is_tx))
		else $error("transmit enable wrong");
	a_tx_unused: assert property (@(posedge REF_CLK) disable iff (!NRST)
		!s_q.conf[CONF_ASSIGN]
		|=> !TX_ENABLED)
		else $error("unused buffer enabled for transmit");

	// register read port
	a_rd_quiet: assert property (@(posedge REF_CLK) disable iff (!NRST)
		!RD
		|=> RDATA == 16'h0000)
		else $error("read data without a read");
	a_rd_byte: assert property (@(posedge REF_CLK) disable iff (!NRST)
		RD && ADDR <= A_BYTE7
		|=> RDATA[15:8] == 8'h00)
		else $error("byte read upper half nonzero");
	a_len_upper: assert property (@(posedge REF_CLK) disable iff (!NRST)
		$past(RD) && $past(ADDR) == A_LEN
		|-> RDATA[7:4] == ZERO4)
		else $error("length upper bits nonzero");
endmodule : msgbuf_fields

/* File: shared/msgbuf_pkg.sv */
// shared constants and carriers for the message buffer field block
package msgbuf_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_BYTES = 8;
	localparam int NUM_W = 4;
	// register indices on the plain register port
	localparam logic [4:0] A_BYTE0 = 5'h00;
	localparam logic [4:0] A_BYTE7 = 5'h07;
	localparam logic [4:0] A_PAIR01 = 5'h08;
	localparam logic [4:0] A_PAIR67 = 5'h0B;
	localparam logic [4:0] A_LEN = 5'h0C;
	localparam logic [4:0] A_CONF = 5'h0D;
	localparam logic [4:0] A_IDL = 5'h0E;
	localparam logic [4:0] A_IDH = 5'h0F;
	localparam logic [4:0] A_CTRL = 5'h10;
	// field positions
	localparam int CONF_OWS = 7;
	localparam int CONF_RTR = 6;
	localparam int CONF_MT_LO = 3;
	localparam int CONF_ASSIGN = 0;
	localparam int IDH_IDE = 15;
	localparam int CTRL_DN = 0;
	localparam int CTRL_TRQ = 1;
	localparam int CTRL_OVW = 2;
	localparam logic [7:0] CONF_WMASK = 8'hF9;
	localparam logic [15:0] IDH_WMASK = 16'h9FFF;
	localparam logic [3:0] LEN_MAX = 4'h8;
	localparam logic [2:0] MT_TX = 3'h0;
	localparam logic [2:0] MT_RX_LAST = 3'h5;
	localparam logic [17:0] STD_LOW_ZERO = 18'h00000;
	localparam logic [3:0] ZERO4 = 4'h0;
	// frame as seen by the protocol engine
	typedef struct packed {
		logic ext;
		logic [28:0] id;
		logic remote;
		logic [3:0] dlc;
		logic [63:0] data;
	} frame_t;
	typedef struct packed {
		logic [63:0] data;
		logic [3:0] len;
		logic [7:0] conf;
		logic [15:0] idl;
		logic [15:0] idh;
		logic dn;
		logic transmit_request_bit;
		logic ovw;
		logic [15:0] rdata;
		logic store_ack;
		logic drop_ack;
	} state_t;
endpackage : msgbuf_pkg

/* File: verif/engine_model.sv */
// protocol engine stand-in offering frames to the buffer
`timescale 1ns/1ps
module engine_model (
	// clock
	input wire logic REF_CLK,
	// offer request from the bench
	input wire logic go,
	input msgbuf_pkg::frame_t frame,
	// offer towards the buffer
	output logic RX_VALID,
	output msgbuf_pkg::frame_t RX_FRAME
);
	import msgbuf_pkg::*;
	// idle frame lines show the inverse so a stale frame never looks valid
	always @(posedge REF_CLK) begin
		RX_VALID <= go;
		RX_FRAME <= go ? frame : ~frame;
	end
endmodule : engine_model

/* File: verif/testbench.sv */
// self-checking bench for one message buffer
`timescale 1ns/1ps
module testbench;
	import msgbuf_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [15:0] wdata = '0, rdata;
	frame_t fr = '0, tx_frame, rx_frame;
	logic [NUM_W-1:0] tx_nbytes;
	logic tx_en, rx_valid, rx_stored, rx_dropped, assigned, id_ext, dn;
	logic [2:0] buf_type;
	int bad_count = 0;
	int samples_checked = 0;
	always #12.5 ref_clk = ~ref_clk;
	msgbuf_fields i_msgbuf_fields (.REF_CLK(ref_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .TX_FRAME(tx_frame), .TX_NBYTES(tx_nbytes),
		.TX_ENABLED(tx_en), .RX_VALID(rx_valid), .RX_FRAME(rx_frame), .RX_STORED(rx_stored),
		.RX_DROPPED(rx_dropped), .BUF_TYPE(buf_type), .BUF_ASSIGNED(assigned),
		.ID_EXT(id_ext), .DATA_STORED(dn));
	engine_model i_engine_model (.REF_CLK(ref_clk), .go(go), .frame(fr),
		.RX_VALID(rx_valid), .RX_FRAME(rx_frame));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 chk($sformatf("register %0h", a), exp, rdata);
	endtask : rd_reg
	// every offered frame carries the standard id the buffer holds
	task automatic offer(input logic rem, input logic [3:0] dlc, input logic [63:0] d,
		input logic ok);
		@(posedge ref_clk);
		go <= 1'b1;
		fr <= '{1'b0, {13'h1234, 16'h0000}, rem, dlc, d};
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
		#1 chk("stored,dropped", {ok, !ok}, {rx_stored, rx_dropped});
	endtask : offer
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic scen_alias;
		wr_reg(A_PAIR67, 16'hA55A);
		rd_reg(A_BYTE7 - 5'h01, 16'h005A);
		rd_reg(A_BYTE7, 16'h00A5);
	endtask : scen_alias
	task automatic scen_tx;
		wr_reg(A_IDH, 16'h1234);
		wr_reg(A_IDL, 16'hFFFF);
		wr_reg(A_LEN, 16'h0009);
		wr_reg(A_CONF, 16'h0001);
		wr_reg(A_CTRL, 16'h0002);
		settle();
		chk("byte count", 64'h8, tx_nbytes);
		chk("length code", 64'h9, tx_frame.dlc);
		chk("enabled,assigned", 64'h3, {tx_en, assigned});
		chk("identifier", 64'h12340000, {id_ext, tx_frame.id});
		chk("remote", 64'h0, tx_frame.remote);
		chk("data", 64'hA55A000000000000, tx_frame.data);
		wr_reg(A_CONF, 16'h0041);
		settle();
		chk("remote,count", 64'h10, {tx_frame.remote, tx_nbytes});
	endtask : scen_tx
	task automatic scen_remote;
		offer(1'b1, 4'h5, 64'h0, 1'b0);
		wr_reg(A_CTRL, 16'h0000);
		offer(1'b1, 4'h5, 64'h0, 1'b0);
		wr_reg(A_CONF, 16'h0001);
		offer(1'b1, 4'h5, 64'h0, 1'b1);
		rd_reg(A_CONF, 16'h0001);
		rd_reg(A_LEN, 16'h0005);
		chk("stored flag", 64'h1, dn);
		offer(1'b1, 4'h2, 64'h0, 1'b1);
	endtask : scen_remote
	task automatic scen_rx;
		wr_reg(A_CTRL, 16'h0001);
		wr_reg(A_CONF, 16'h0009);
		offer(1'b0, 4'h3, 64'h332211, 1'b1);
		rd_reg(A_PAIR01, 16'h2211);
		rd_reg(A_BYTE0 + 5'h02, 16'h0033);
		chk("type", 64'h1, buf_type);
		offer(1'b0, 4'h1, 64'h77, 1'b0);
		rd_reg(A_BYTE0, 16'h0011);
		wr_reg(A_CONF, 16'h0089);
		offer(1'b0, 4'hC, 64'h8877665544332211, 1'b1);
		rd_reg(A_BYTE7, 16'h0088);
		rd_reg(A_CTRL, 16'h0005);
		wr_reg(A_IDH, 16'h8001);
		wr_reg(A_IDL, 16'h2345);
		settle();
		chk("extended id", 64'h20012345, {id_ext, tx_frame.id});
	endtask : scen_rx
	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		rd_reg(A_LEN, 16'h0000);
		scen_alias();
		scen_tx();
		scen_remote();
		scen_rx();
		give_verdict();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		give_verdict();
	end
endmodule : testbench
